// [pkg/sbl_pkg.sv]
// package: command codes, bank states and timing constants for the bank legality block
package sbl_pkg;
  localparam int unsigned sbl_clk_mhz = 50;
  // timing figures in ns; cycle counts derived below, least times round up
  localparam int unsigned sbl_precharge_time_ns = 20;
  localparam int unsigned sbl_activate_to_column_time_ns = 20;
  localparam int unsigned sbl_refresh_cycle_time_ns = 120;
  localparam int unsigned sbl_mode_register_set_time_ns = 15;
  localparam int unsigned sbl_write_recovery_time_ns = 15;
  localparam int unsigned sbl_write_to_read_time_ns = 8;
  localparam int unsigned sbl_self_refresh_exit_time_ns = 200;
  function automatic int unsigned sbl_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * sbl_clk_mhz + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : sbl_cyc
  localparam int unsigned sbl_rp_cyc = sbl_cyc(sbl_precharge_time_ns);
  localparam int unsigned sbl_rcd_cyc = sbl_cyc(sbl_activate_to_column_time_ns);
  localparam int unsigned sbl_rfc_cyc = sbl_cyc(sbl_refresh_cycle_time_ns);
  localparam int unsigned sbl_mrd_cyc = sbl_cyc(sbl_mode_register_set_time_ns);
  localparam int unsigned sbl_wr_cyc = sbl_cyc(sbl_write_recovery_time_ns);
  localparam int unsigned sbl_wtr_cyc = sbl_cyc(sbl_write_to_read_time_ns);
  localparam int unsigned sbl_xsnr_cyc = sbl_cyc(sbl_self_refresh_exit_time_ns);
  localparam int unsigned sbl_burst_length = 4;
  localparam int unsigned sbl_read_latency = 3;
  localparam int unsigned sbl_banks = 4;
  localparam int unsigned sbl_cnt_w = 8;
  localparam int unsigned sbl_addr_w = 14;
  localparam int unsigned sbl_ap_bit = 10;
  // command codes: {row_strobe_n, column_strobe_n, write_strobe_n}
  localparam logic [2:0] sbl_c_nop = 3'h7;
  localparam logic [2:0] sbl_c_act = 3'h3;
  localparam logic [2:0] sbl_c_rd = 3'h5;
  localparam logic [2:0] sbl_c_wr = 3'h4;
  localparam logic [2:0] sbl_c_pre = 3'h2;
  localparam logic [2:0] sbl_c_bst = 3'h6;
  localparam logic [2:0] sbl_c_ref = 3'h1;
  localparam logic [2:0] sbl_c_lmr = 3'h0;
  typedef enum logic [3:0] {
    sbl_nop, sbl_act, sbl_rd, sbl_wr, sbl_pre, sbl_bst, sbl_ref, sbl_lmr, sbl_desel
  } sbl_cmd_e;
  typedef enum logic [3:0] {
    sbl_idle, sbl_activating, sbl_row_active, sbl_reading, sbl_writing,
    sbl_read_ap, sbl_write_ap, sbl_precharging
  } sbl_bank_e;
  typedef enum logic [1:0] {sbl_g_none, sbl_g_refresh, sbl_g_mode, sbl_g_pre_all} sbl_glob_e;
  // shared command decode
  function automatic sbl_cmd_e sbl_decode(input logic cs_n, input logic [2:0] rcw);
    if (cs_n) return sbl_desel;
    case (rcw)
      sbl_c_nop: return sbl_nop;
      sbl_c_act: return sbl_act;
      sbl_c_rd: return sbl_rd;
      sbl_c_wr: return sbl_wr;
      sbl_c_pre: return sbl_pre;
      sbl_c_bst: return sbl_bst;
      sbl_c_ref: return sbl_ref;
      default: return sbl_lmr;
    endcase
  endfunction : sbl_decode
endpackage : sbl_pkg

// [pkg/sbl_if.sv]
// interface: command pins between memory controller and bank legality device
`timescale 1ns/100ps
interface sbl_if;
  import sbl_pkg::*;
  logic clock_enable;
  logic chip_select_n;
  logic row_strobe_n;
  logic column_strobe_n;
  logic write_strobe_n;
  logic bank_select_0;
  logic bank_select_1;
  logic [sbl_addr_w-1:0] address;
  logic data_mask;
  modport ctrl (output clock_enable, output chip_select_n, output row_strobe_n,
    output column_strobe_n, output write_strobe_n, output bank_select_0,
    output bank_select_1, output address, output data_mask);
  modport dev (input clock_enable, input chip_select_n, input row_strobe_n,
    input column_strobe_n, input write_strobe_n, input bank_select_0,
    input bank_select_1, input address, input data_mask);
endinterface : sbl_if

// [verilog/sbl_device.sv]
// device end: per-bank state tracking and command legality checking
// Behaviour
// - decode command from four control strobes
// - rules apply only with enable high twice
// - idle after precharge time, active after activate
// - read state lasts until burst ends, write state until write recovery after it
// - row active allows read, write, precharge only
// - read state: read, write, precharge, terminate
// - write state: read, write, precharge; mask data
// - no commands to busy bank
// - activate and precharge complete after their times
// - auto-precharge access busy until precharge done
// - only nop during refresh, mode, precharge-all
// - global operations end at their times, idle
// - refresh and mode load need idle banks
// - multi-bank precharge needs every bank legal
// - terminate acts on most recent read burst
// - write after read waits burst or terminate
// - any other state/command pair is illegal
// - other banks accept commands meanwhile
// - auto precharge start after recovery or burst
// - other banks usable during auto-precharge access
// - spacing after write with auto precharge
// - spacing after read with auto precharge
// - address bit ten selects one or all banks
`timescale 1ns/100ps
module sbl_device #(
  parameter int unsigned xsnr_cycles = sbl_pkg::sbl_xsnr_cyc
) (
  input wire logic clk,
  input wire logic resetn,
  sbl_if.dev pins,
  input wire logic self_refresh_exit,
  output logic illegal_q,
  output logic [3:0] bank_idle_q,
  output logic busy_q
);
  import sbl_pkg::*;
  localparam int unsigned half_bl = sbl_burst_length / 2;
  localparam logic [sbl_cnt_w-1:0] rd_ap_len = sbl_cnt_w'(half_bl + sbl_rp_cyc);
  localparam logic [sbl_cnt_w-1:0] wr_ap_len = sbl_cnt_w'(half_bl + 1 + sbl_wr_cyc + sbl_rp_cyc);
  localparam logic [sbl_cnt_w-1:0] wr_rd_gap = sbl_cnt_w'(1 + half_bl + sbl_wtr_cyc);
  localparam logic [sbl_cnt_w-1:0] rd_wr_gap = sbl_cnt_w'(sbl_read_latency + half_bl);
  localparam logic [sbl_cnt_w-1:0] bl_gap = sbl_cnt_w'(half_bl);
  localparam logic [15:0] xsnr_load = 16'(xsnr_cycles);
  // pins come from another party; two flops first
  logic [21:0] s1_q, s2_q;
  always_ff @(posedge clk) begin
    s1_q <= {pins.clock_enable, pins.chip_select_n, pins.row_strobe_n, pins.column_strobe_n,
      pins.write_strobe_n, pins.bank_select_1, pins.bank_select_0, pins.address, pins.data_mask};
    s2_q <= s1_q;
  end
  wire cke = s2_q[21];
  wire [1:0] bank = s2_q[16:15];
  wire ap = s2_q[1 + sbl_ap_bit];
  wire dm = s2_q[0];
  wire sbl_cmd_e cmd = sbl_decode(s2_q[20], s2_q[19:17]);
  logic cke_prev_q;
  logic [15:0] xsnr_q;
  wire active = cke && cke_prev_q && (xsnr_q == 16'h0000);
  sbl_bank_e st_q [sbl_banks];
  logic [sbl_cnt_w-1:0] cnt_q [sbl_banks];
  sbl_glob_e glob_q;
  logic [sbl_cnt_w-1:0] gcnt_q;
  logic [1:0] last_rd_q;
  logic rd_live_q;
  logic [sbl_cnt_w-1:0] rd_left_q, wr_gap_q, rdap_gap_q, wrap_rd_q, wrap_wr_q;
  logic wr_mask_err_q;
  // per-bank legality of the decoded command
  logic [3:0] ok_b;
  logic all_idle;
  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < sbl_banks; b++) begin
      all_idle = all_idle && (st_q[b] == sbl_idle);
      case (st_q[b])
        sbl_idle: ok_b[b] = (cmd == sbl_act) || (cmd == sbl_pre);
        sbl_row_active: ok_b[b] = (cmd == sbl_rd) || (cmd == sbl_wr) || (cmd == sbl_pre);
        sbl_reading: ok_b[b] = (cmd == sbl_rd) || (cmd == sbl_pre) ||
          ((cmd == sbl_wr) && !rd_live_q);
        sbl_writing: ok_b[b] = (cmd == sbl_rd) || (cmd == sbl_wr) || (cmd == sbl_pre);
        default: ok_b[b] = 1'b0; // busy states take nothing
      endcase
    end
  end
  wire all_banks = (cmd == sbl_pre) && ap;
  wire bank_cmd = (cmd == sbl_act) || (cmd == sbl_rd) || (cmd == sbl_wr) || (cmd == sbl_pre);
  wire quiet = (cmd == sbl_nop) || (cmd == sbl_desel);
  wire pre_all_ok = ok_b == 4'hf;
  wire spacing_ok = !(((cmd == sbl_rd) && (wrap_rd_q != 0 || rdap_gap_q != 0)) ||
    ((cmd == sbl_wr) && (wrap_wr_q != 0 || wr_gap_q != 0)));
  wire bad = active && !quiet && (
    (glob_q != sbl_g_none) ||
    (((cmd == sbl_ref) || (cmd == sbl_lmr)) && !(all_idle && !rd_live_q)) ||
    (all_banks ? !pre_all_ok : (bank_cmd && !(ok_b[bank] && spacing_ok))) ||
    ((cmd == sbl_bst) && !rd_live_q));
  wire take = active && !bad;
  // per-bank state machines with own counters
  always_ff @(posedge clk) begin
    for (int b = 0; b < sbl_banks; b++) begin
      if (!resetn) begin
        st_q[b] <= sbl_idle;
        cnt_q[b] <= '0;
      end else if (take && glob_q == sbl_g_none && (all_banks || bank == 2'(b)) && bank_cmd) begin
        case (cmd)
          sbl_act: begin st_q[b] <= sbl_activating; cnt_q[b] <= sbl_cnt_w'(sbl_rcd_cyc); end
          sbl_pre: begin st_q[b] <= sbl_precharging; cnt_q[b] <= sbl_cnt_w'(sbl_rp_cyc); end
          sbl_rd: begin
            st_q[b] <= ap ? sbl_read_ap : sbl_reading;
            cnt_q[b] <= ap ? rd_ap_len : bl_gap;
          end
          default: begin
            st_q[b] <= ap ? sbl_write_ap : sbl_writing;
            cnt_q[b] <= ap ? wr_ap_len : sbl_cnt_w'(half_bl + 1 + sbl_wr_cyc);
          end
        endcase
      end else if (take && cmd == sbl_bst && last_rd_q == 2'(b) && st_q[b] == sbl_reading) begin
        st_q[b] <= sbl_row_active;
      end else if (cnt_q[b] > 1) begin
        cnt_q[b] <= cnt_q[b] - 1'b1;
      end else if (cnt_q[b] == 1) begin
        cnt_q[b] <= '0;
        case (st_q[b])
          sbl_activating, sbl_reading, sbl_writing: st_q[b] <= sbl_row_active;
          default: st_q[b] <= sbl_idle;
        endcase
      end
    end
  end
  // global operations, read tracking and spacing counters
  always_ff @(posedge clk) begin
    if (!resetn) begin
      glob_q <= sbl_g_none;
      gcnt_q <= '0;
      last_rd_q <= 2'h0;
      rd_live_q <= 1'b0;
      rd_left_q <= '0;
      wr_gap_q <= '0;
      rdap_gap_q <= '0;
      wrap_rd_q <= '0;
      wrap_wr_q <= '0;
    end else begin
      if (glob_q != sbl_g_none) begin
        gcnt_q <= gcnt_q - 1'b1;
        if (gcnt_q == 1) glob_q <= sbl_g_none;
      end else if (take && cmd == sbl_ref) begin
        glob_q <= sbl_g_refresh;
        gcnt_q <= sbl_cnt_w'(sbl_rfc_cyc);
      end else if (take && cmd == sbl_lmr) begin
        glob_q <= sbl_g_mode;
        gcnt_q <= sbl_cnt_w'(sbl_mrd_cyc);
      end else if (take && all_banks) begin
        glob_q <= sbl_g_pre_all;
        gcnt_q <= sbl_cnt_w'(sbl_rp_cyc);
      end
      rd_left_q <= (rd_left_q != 0) ? rd_left_q - 1'b1 : rd_left_q;
      wr_gap_q <= (wr_gap_q != 0) ? wr_gap_q - 1'b1 : wr_gap_q;
      rdap_gap_q <= (rdap_gap_q != 0) ? rdap_gap_q - 1'b1 : rdap_gap_q;
      wrap_rd_q <= (wrap_rd_q != 0) ? wrap_rd_q - 1'b1 : wrap_rd_q;
      wrap_wr_q <= (wrap_wr_q != 0) ? wrap_wr_q - 1'b1 : wrap_wr_q;
      if (rd_left_q == 1) rd_live_q <= 1'b0;
      if (take && cmd == sbl_rd) begin
        last_rd_q <= bank;
        rd_live_q <= 1'b1;
        rd_left_q <= bl_gap;
        wr_gap_q <= rd_wr_gap;
        if (ap) rdap_gap_q <= bl_gap - 1'b1;
      end else if (take && cmd == sbl_bst) begin
        rd_live_q <= 1'b0;
        rd_left_q <= '0;
        wr_gap_q <= '0;
      end
      if (take && cmd == sbl_wr && ap) begin
        wrap_rd_q <= wr_rd_gap - 1'b1;
        wrap_wr_q <= bl_gap - 1'b1;
      end
    end
  end
  // interrupting a write with read or single-bank precharge needs masked data
  always_ff @(posedge clk) begin
    if (!resetn) wr_mask_err_q <= 1'b0;
    else wr_mask_err_q <= take && (cmd == sbl_rd || cmd == sbl_pre) && !all_banks &&
      st_q[bank] == sbl_writing && !dm;
  end
  // self refresh exit wait and enable history
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cke_prev_q <= 1'b0;
      xsnr_q <= 16'h0000;
    end else begin
      cke_prev_q <= cke;
      if (self_refresh_exit) xsnr_q <= xsnr_load;
      else if (xsnr_q != 0) xsnr_q <= xsnr_q - 1'b1;
    end
  end
  // registered outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      illegal_q <= 1'b0;
      bank_idle_q <= 4'hf;
      busy_q <= 1'b0;
    end else begin
      illegal_q <= bad || wr_mask_err_q;
      for (int b = 0; b < sbl_banks; b++) bank_idle_q[b] <= st_q[b] == sbl_idle;
      busy_q <= glob_q != sbl_g_none;
    end
  end
endmodule : sbl_device

// [verilog/sbl_controller.sv]
// controller end: drives one user command onto the pins as a one-cycle strobe
`timescale 1ns/100ps
module sbl_controller (
  input wire logic clk,
  input wire logic resetn,
  sbl_if.ctrl pins,
  input wire logic req_valid,
  input wire sbl_pkg::sbl_cmd_e req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [sbl_pkg::sbl_addr_w-1:0] req_addr,
  input wire logic req_mask,
  input wire logic req_cke,
  output logic req_ready_q
);
  import sbl_pkg::*;
  logic [2:0] rcw_q;
  logic cs_n_q, cke_q, dm_q;
  logic [1:0] ba_q;
  logic [sbl_addr_w-1:0] addr_q;
  wire [2:0] code_d = (req_cmd == sbl_act) ? sbl_c_act : (req_cmd == sbl_rd) ? sbl_c_rd :
    (req_cmd == sbl_wr) ? sbl_c_wr : (req_cmd == sbl_pre) ? sbl_c_pre :
    (req_cmd == sbl_bst) ? sbl_c_bst : (req_cmd == sbl_ref) ? sbl_c_ref :
    (req_cmd == sbl_lmr) ? sbl_c_lmr : sbl_c_nop;
  wire issue = req_valid && req_cmd != sbl_desel && req_cmd != sbl_nop;
  // legality is the user's duty
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_n_q <= 1'b1;
      rcw_q <= sbl_c_nop;
      cke_q <= 1'b0;
      ba_q <= 2'h0;
      addr_q <= '0;
      dm_q <= 1'b0;
      req_ready_q <= 1'b0;
    end else begin
      cs_n_q <= !(req_valid && req_cmd != sbl_desel);
      rcw_q <= issue ? code_d : sbl_c_nop;
      cke_q <= req_cke;
      ba_q <= req_bank;
      addr_q <= req_addr;
      dm_q <= req_mask;
      req_ready_q <= 1'b1;
    end
  end
  assign pins.chip_select_n = cs_n_q;
  assign pins.row_strobe_n = rcw_q[2];
  assign pins.column_strobe_n = rcw_q[1];
  assign pins.write_strobe_n = rcw_q[0];
  assign pins.clock_enable = cke_q;
  assign pins.bank_select_0 = ba_q[0];
  assign pins.bank_select_1 = ba_q[1];
  assign pins.address = addr_q;
  assign pins.data_mask = dm_q;
endmodule : sbl_controller

// [test/sbl_assertions.sv]
// checker: pin-level timing and legality relations of the bank legality block
`timescale 1ns/100ps
module sbl_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [sbl_pkg::sbl_addr_w-1:0] address,
  input wire logic illegal_q,
  input wire logic [3:0] bank_idle_q,
  input wire logic busy_q
);
  import sbl_pkg::*;
  // command decode seen on the pins
  wire [2:0] rcw = {row_strobe_n, column_strobe_n, write_strobe_n};
  wire cmd_c = !chip_select_n && rcw != sbl_c_nop;
  wire act_c = cmd_c && rcw == sbl_c_act;
  wire ref_c = cmd_c && rcw == sbl_c_ref;
  wire lmr_c = cmd_c && rcw == sbl_c_lmr;
  wire pre_c = cmd_c && rcw == sbl_c_pre;
  wire bst_c = cmd_c && rcw == sbl_c_bst;
  wire [1:0] bsel = {bank_select_1, bank_select_0};
  logic [7:0] age_q;
  logic cke_q;
  // quiet: nothing still in flight through the device's sync pipeline
  wire quiet = age_q >= 8'h08 && cke_q && clock_enable;
  wire all_idle = quiet && bank_idle_q == 4'hf && !busy_q;
  // cycles since last command, saturating so long gaps stay quiet
  always_ff @(posedge clk) begin
    if (!resetn) begin
      age_q <= 8'hff;
      cke_q <= 1'b0;
    end else begin
      age_q <= cmd_c ? 8'h00 : ((age_q == 8'hff) ? age_q : age_q + 8'h01);
      cke_q <= clock_enable;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_reset_deselect: assert property ($rose(resetn) |-> chip_select_n && !clock_enable)
    else $error("pins not deselected after reset");
  // flag of a later command lands three cycles after it, so look no further than this one's slot
  chk_act_legal: assert property (act_c && all_idle |=> !illegal_q [*3])
    else $error("legal activate flagged");
  chk_act_opens: assert property (act_c && all_idle |-> ##[1:5] bank_idle_q != 4'hf)
    else $error("activate left every bank idle");
  chk_act_twice: assert property (
    act_c && quiet ##2 (act_c && bsel == $past(bsel, 2)) |-> ##[1:5] illegal_q)
    else $error("second activate to busy bank not flagged");
  chk_ref_busy: assert property (
    ref_c && all_idle |-> ##[1:4] busy_q ##1 busy_q [*3] ##[1:8] !busy_q)
    else $error("refresh busy span wrong");
  chk_ref_lockout: assert property (ref_c && all_idle ##2 cmd_c |-> ##[1:5] illegal_q)
    else $error("command during refresh not flagged");
  chk_lmr_short: assert property (lmr_c && all_idle |-> ##[1:4] busy_q ##[1:4] !busy_q)
    else $error("mode load busy span wrong");
  chk_ref_needs_idle: assert property (
    ref_c && quiet && !busy_q && bank_idle_q != 4'hf |-> ##[1:5] illegal_q)
    else $error("refresh with open bank not flagged");
  chk_bst_orphan: assert property (bst_c && quiet |-> ##[1:5] illegal_q)
    else $error("terminate with no read burst not flagged");
  chk_flag_cause: assert property (illegal_q |-> age_q <= 8'h06)
    else $error("illegal flag with no command");
  chk_preall_idle: assert property (
    pre_c && address[sbl_ap_bit] && quiet && !busy_q |-> ##[1:8] bank_idle_q == 4'hf)
    else $error("precharge all left a bank open");
  cov_refresh: cover property (ref_c && all_idle);
  cov_flag: cover property (illegal_q);
  cov_preall: cover property (pre_c && address[sbl_ap_bit]);
endmodule : sbl_assertions

// [test/tb_sdram_bank_command_legality.sv]
// testbench: controller and device ends joined over the command pins
`timescale 1ns/100ps
module tb_sdram_bank_command_legality;
  import sbl_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  sbl_cmd_e req_cmd = sbl_nop;
  logic [1:0] req_bank = 2'h0;
  logic [sbl_addr_w-1:0] req_addr = 14'h0000;
  logic req_mask = 1'b0;
  logic req_cke = 1'b1;
  logic self_refresh_exit = 1'b0;
  logic req_ready_q, illegal_q, busy_q;
  logic [3:0] bank_idle_q;
  int err_total = 0;
  int n_checks = 0;
  int ill_cnt = 0;
  int cyc = 0;
  sbl_if pins ();
  sbl_controller i_sbl_controller (.clk(clk), .resetn(resetn), .pins(pins),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_mask(req_mask), .req_cke(req_cke), .req_ready_q(req_ready_q));
  // exit wait shortened so the cke scenario stays brief
  sbl_device #(.xsnr_cycles(2)) i_sbl_device (.clk(clk), .resetn(resetn), .pins(pins),
    .self_refresh_exit(self_refresh_exit), .illegal_q(illegal_q),
    .bank_idle_q(bank_idle_q), .busy_q(busy_q));
  sbl_assertions i_sbl_assertions (.clk(clk), .resetn(resetn),
    .clock_enable(pins.clock_enable), .chip_select_n(pins.chip_select_n),
    .row_strobe_n(pins.row_strobe_n), .column_strobe_n(pins.column_strobe_n),
    .write_strobe_n(pins.write_strobe_n), .bank_select_0(pins.bank_select_0),
    .bank_select_1(pins.bank_select_1), .address(pins.address), .illegal_q(illegal_q),
    .bank_idle_q(bank_idle_q), .busy_q(busy_q));
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  // flag pulses last one cycle, so count them as they pass; cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (illegal_q === 1'b1) ill_cnt++;
    if (cyc == 4000) begin
      err_total++;
      results();
    end
  end
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    #1;
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // one request, held for exactly the edge that takes it
  task automatic send(input sbl_cmd_e c, input logic [1:0] b, input logic ap, input logic m);
    for (int i = 0; i < 8 && req_ready_q !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= {3'h0, ap, 10'h000};
    req_mask <= m;
    @(posedge clk);
    req_valid <= 1'b0;
    req_mask <= 1'b0;
  endtask : send
  task automatic t_basic();
    int base = ill_cnt;
    idle(10);
    send(sbl_act, 2'h1, 1'b0, 1'b0);
    send(sbl_act, 2'h2, 1'b0, 1'b0);
    idle(6);
    check("bank idle after act", bank_idle_q, 4'h9);
    send(sbl_rd, 2'h1, 1'b0, 1'b0);
    idle(8);
    send(sbl_wr, 2'h1, 1'b0, 1'b0);
    idle(8);
    send(sbl_pre, 2'h1, 1'b0, 1'b0);
    idle(6);
    check("bank idle after pre", bank_idle_q, 4'hb);
    idle(10);
    send(sbl_pre, 2'h0, 1'b1, 1'b0);
    idle(8);
    check("bank idle after pre all", bank_idle_q, 4'hf);
    check("illegal count basic", 4'(ill_cnt - base), 4'h0);
    $display("test basic done");
  endtask : t_basic
  task automatic t_illegal();
    int base = ill_cnt;
    idle(10);
    send(sbl_rd, 2'h0, 1'b0, 1'b0);
    idle(10);
    send(sbl_bst, 2'h0, 1'b0, 1'b0);
    idle(10);
    send(sbl_act, 2'h2, 1'b0, 1'b0);
    send(sbl_act, 2'h2, 1'b0, 1'b0);
    idle(6);
    send(sbl_wr, 2'h2, 1'b0, 1'b0);
    send(sbl_rd, 2'h2, 1'b0, 1'b0);
    idle(8);
    send(sbl_wr, 2'h2, 1'b0, 1'b0);
    send(sbl_rd, 2'h2, 1'b0, 1'b1);
    idle(8);
    send(sbl_pre, 2'h2, 1'b0, 1'b0);
    idle(8);
    check("illegal count refused", 4'(ill_cnt - base), 4'h4);
    check("bank idle after refused", bank_idle_q, 4'hf);
    $display("test illegal done");
  endtask : t_illegal
  task automatic t_global();
    int base = ill_cnt;
    idle(10);
    send(sbl_ref, 2'h0, 1'b0, 1'b0);
    send(sbl_act, 2'h0, 1'b0, 1'b0);
    idle(3);
    check("busy in refresh", {3'h0, busy_q}, 4'h1);
    idle(12);
    check("busy after refresh", {3'h0, busy_q}, 4'h0);
    check("bank idle after refresh", bank_idle_q, 4'hf);
    send(sbl_lmr, 2'h0, 1'b0, 1'b0);
    idle(10);
    check("busy after mode load", {3'h0, busy_q}, 4'h0);
    send(sbl_act, 2'h3, 1'b0, 1'b0);
    idle(10);
    send(sbl_ref, 2'h0, 1'b0, 1'b0);
    idle(10);
    send(sbl_pre, 2'h3, 1'b0, 1'b0);
    idle(8);
    check("illegal count global", 4'(ill_cnt - base), 4'h2);
    $display("test global done");
  endtask : t_global
  task automatic t_autopre();
    int base = ill_cnt;
    idle(10);
    send(sbl_act, 2'h3, 1'b0, 1'b0);
    send(sbl_act, 2'h0, 1'b0, 1'b0);
    idle(4);
    send(sbl_wr, 2'h3, 1'b1, 1'b0);
    // read to the other bank two clocks after a write with auto precharge: too soon
    send(sbl_rd, 2'h0, 1'b0, 1'b0);
    idle(12);
    check("bank idle after write ap", bank_idle_q, 4'he);
    send(sbl_rd, 2'h0, 1'b1, 1'b0);
    idle(12);
    check("bank idle after read ap", bank_idle_q, 4'hf);
    check("illegal count ap", 4'(ill_cnt - base), 4'h1);
    $display("test autopre done");
  endtask : t_autopre
  task automatic t_cke();
    int base = ill_cnt;
    idle(10);
    req_cke <= 1'b0;
    idle(4);
    send(sbl_bst, 2'h0, 1'b0, 1'b0);
    idle(4);
    req_cke <= 1'b1;
    self_refresh_exit <= 1'b1;
    idle(1);
    self_refresh_exit <= 1'b0;
    idle(10);
    send(sbl_act, 2'h1, 1'b0, 1'b0);
    idle(6);
    check("bank idle after wake", bank_idle_q, 4'hd);
    check("illegal count cke", 4'(ill_cnt - base), 4'h0);
    $display("test cke done");
  endtask : t_cke
  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_basic();
    t_illegal();
    t_global();
    t_autopre();
    t_cke();
    results();
  end
endmodule : tb_sdram_bank_command_legality
